// *** pkg/wake_filter_defines.vh ***
`ifndef WAKE_FILTER_DEFINES_VH
`define WAKE_FILTER_DEFINES_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define WF_ADDR_W            16
`define WF_OFF_FILTER_EN     16'h5808
`define WF_OFF_EVENT_STAT    16'h5810
`define WF_OFF_PORT_LOW      16'h5828
`define WF_OFF_PORT_HIGH     16'h5830
`define WF_OFF_ADDR_VALID    16'h5838
`define WF_OFF_IPV4_0        16'h5840
`define WF_OFF_IPV4_1        16'h5848
`define WF_OFF_IPV4_2        16'h5850
`define WF_OFF_IPV4_3        16'h5858

// ----------------------------------------
// Register select codes
// ----------------------------------------
`define WF_SEL_W             9
`define WF_SEL_FILTER_EN     0
`define WF_SEL_EVENT_STAT    1
`define WF_SEL_PORT_LOW      2
`define WF_SEL_PORT_HIGH     3
`define WF_SEL_ADDR_VALID    4
`define WF_SEL_IPV4_0        5

// ----------------------------------------
// Filter enable / event status fields
// ----------------------------------------
`define WF_BIT_LINK_CHANGE   0
`define WF_BIT_PATTERN_PKT   1
`define WF_BIT_EXACT_ADDR    2
`define WF_BIT_MCAST_HASH    3
`define WF_BIT_BROADCAST     4
`define WF_BIT_ARP_REQ       5
`define WF_BIT_DIRECT_IPV4   6
`define WF_BIT_DIRECT_IPV6   7
`define WF_BIT_MGMT_FLEX0    9
`define WF_BIT_MGMT_FLEX1    10
`define WF_BIT_IGNORE_MGMT   15
`define WF_BIT_FLEX_LO       16
`define WF_MASK_FILTER_EN    32'h000f80ff
`define WF_MASK_WAKE_EN      32'h000f00ff
`define WF_MASK_EVENT_STAT   32'h000f06ff
`define WF_RST_FILTER_EN     32'h00000000
`define WF_RST_EVENT_STAT    32'h00000000

// ----------------------------------------
// Port pairs and address valid fields
// ----------------------------------------
`define WF_PORT_W            16
`define WF_RST_PORT          16'h0000
`define WF_BIT_IPV4_VALID_LO 0
`define WF_BIT_IPV6_VALID    16
`define WF_MASK_ADDR_VALID   32'h0001000f
`define WF_RST_ADDR_VALID    32'h00000000
`define WF_IPV4_ENTRIES      4
`define WF_RST_IPV4          32'h00000000

`endif

// *** design/ipv4_match.v ***
`timescale 1ns/1ps
`include "wake_filter_defines.vh"

module ipv4_match #(
	parameter ENTRIES = `WF_IPV4_ENTRIES
) (
	// Stored table, entry i in bits 32*i+31:32*i
	input  wire [32*ENTRIES-1:0] table_flat,
	input  wire [ENTRIES-1:0]    entry_valid,
	// Packet address, first wire byte in bits 7:0
	input  wire [31:0]           pkt_ip,
	// Compare result
	output wire [ENTRIES-1:0]    hit
);

	// ----------------------------------------
	// Per-entry compare
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < ENTRIES; i = i + 1) begin : g_cmp
			// Both sides keep the wire's first byte low, so a plain
			// word compare matches byte for byte
			assign hit[i] = entry_valid[i] & (table_flat[32*i +: 32] == pkt_ip);
		end
	endgenerate

endmodule

// *** design/wake_filter_regs.v ***
// Summary of operation
// - Enable bit one turns filter on
// - Enable bits 0-7 and 16-19 placed
// - Bit 15 blocks wake from management packets
// - Status sets every matched criterion bit of a waking packet
// - Write one clears status, zero keeps
// - Status survives host reset, power-on clears
// - Bit 2 marks exact address match
// - Bits 9,10 set only when allocated
// - Bits 16-19 report flex filter matches
// - Four ports, two per word, dual writers
// - Valid bits 0-3 IPv4, 16 IPv6
// - Entry 0 valid loaded from NVM
// - Four IPv4 entries at 8-byte spacing
// - Entry 0 also steers management traffic
// - Least significant byte first on wire
`timescale 1ns/1ps
`include "wake_filter_defines.vh"

module wake_filter_regs #(
	parameter ADDR_W  = `WF_ADDR_W,
	parameter PORT_W  = `WF_PORT_W,
	parameter ENTRIES = `WF_IPV4_ENTRIES
) (
	// Clock, resets, enable
	input  wire                  clk,
	input  wire                  srst,
	input  wire                  por_rst,
	input  wire                  ce,
	// Host register port
	input  wire [ADDR_W-1:0]     reg_addr,
	input  wire                  reg_wr,
	input  wire [31:0]           reg_wdata,
	input  wire                  reg_rd,
	output reg  [31:0]           reg_rdata_r,
	output reg                   reg_rvalid_r,
	// Management bus port writes
	input  wire                  mgmt_port_wr,
	input  wire [1:0]            mgmt_port_idx,
	input  wire [PORT_W-1:0]     mgmt_port_data,
	// NVM load of entry 0 valid
	input  wire                  nvm_load,
	input  wire                  nvm_ip_valid,
	// Packet results from the filter engines
	input  wire                  pkt_done,
	input  wire [31:0]           pkt_match,
	input  wire                  pkt_mgmt_pass,
	input  wire [1:0]            mgmt_flex_alloc,
	input  wire [31:0]           pkt_dst_ip,
	// Configuration toward the filter engines
	output reg  [31:0]           filter_enable_r,
	output reg                   ignore_mgmt_packets_r,
	output reg  [4*PORT_W-1:0]   mgmt_ports_r,
	output reg  [ENTRIES-1:0]    ipv4_valid_r,
	output reg                   ipv6_entry_valid_r,
	output reg  [32*ENTRIES-1:0] ipv4_table_r,
	// Results
	output reg                   wake_event_r,
	output reg  [31:0]           wake_status_r,
	output reg  [ENTRIES-1:0]    ipv4_hit_r,
	output reg                   mgmt_ip_hit_r
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// One-hot select; zero for unmapped offsets
	function [`WF_SEL_W-1:0] reg_sel;
		input [ADDR_W-1:0] a;
		begin
			reg_sel = {`WF_SEL_W{1'b0}};
			case (a)
				`WF_OFF_FILTER_EN:  reg_sel[`WF_SEL_FILTER_EN]  = 1'b1;
				`WF_OFF_EVENT_STAT: reg_sel[`WF_SEL_EVENT_STAT] = 1'b1;
				`WF_OFF_PORT_LOW:   reg_sel[`WF_SEL_PORT_LOW]   = 1'b1;
				`WF_OFF_PORT_HIGH:  reg_sel[`WF_SEL_PORT_HIGH]  = 1'b1;
				`WF_OFF_ADDR_VALID: reg_sel[`WF_SEL_ADDR_VALID] = 1'b1;
				`WF_OFF_IPV4_0:     reg_sel[`WF_SEL_IPV4_0]     = 1'b1;
				`WF_OFF_IPV4_1:     reg_sel[`WF_SEL_IPV4_0 + 1] = 1'b1;
				`WF_OFF_IPV4_2:     reg_sel[`WF_SEL_IPV4_0 + 2] = 1'b1;
				`WF_OFF_IPV4_3:     reg_sel[`WF_SEL_IPV4_0 + 3] = 1'b1;
				default:            reg_sel = {`WF_SEL_W{1'b0}};
			endcase
		end
	endfunction

	// ----------------------------------------
	// Access strobes
	// ----------------------------------------
	// Read and write in one cycle: the read sees the old value
	wire [`WF_SEL_W-1:0] wr_sel;
	wire [`WF_SEL_W-1:0] rd_sel;

	assign wr_sel = reg_wr ? reg_sel(reg_addr) : {`WF_SEL_W{1'b0}};
	assign rd_sel = reg_sel(reg_addr);

	// ----------------------------------------
	// Filter enables
	// ----------------------------------------
	// Only documented fields are stored, the rest stay zero
	always @(posedge clk) begin
		if (srst) begin
			filter_enable_r <= `WF_RST_FILTER_EN;
		end else if (ce && wr_sel[`WF_SEL_FILTER_EN]) begin
			filter_enable_r <= reg_wdata & `WF_MASK_FILTER_EN;
		end
	end

	// Kept apart from the enables: it gates, it does not match
	always @(posedge clk) begin
		if (srst) begin
			ignore_mgmt_packets_r <= 1'b0;
		end else if (ce && wr_sel[`WF_SEL_FILTER_EN]) begin
			ignore_mgmt_packets_r <= reg_wdata[`WF_BIT_IGNORE_MGMT];
		end
	end

	// ----------------------------------------
	// Wake qualification
	// ----------------------------------------
	reg  [31:0] crit;
	reg  [31:0] enabled_hits;
	reg         any_enabled;
	reg         any_mgmt_flex;
	reg         mgmt_blocked;
	reg         wake_now;

	always @* begin
		crit = pkt_match & `WF_MASK_EVENT_STAT;
		// Management flex matches count only when given to wake
		crit[`WF_BIT_MGMT_FLEX0] = pkt_match[`WF_BIT_MGMT_FLEX0] & mgmt_flex_alloc[0];
		crit[`WF_BIT_MGMT_FLEX1] = pkt_match[`WF_BIT_MGMT_FLEX1] & mgmt_flex_alloc[1];
		enabled_hits = crit & filter_enable_r & `WF_MASK_WAKE_EN;
		any_enabled = |enabled_hits;
		// Bits 9 and 10 have no enable here; allocation is the gate
		any_mgmt_flex = crit[`WF_BIT_MGMT_FLEX0] | crit[`WF_BIT_MGMT_FLEX1];
		mgmt_blocked = ignore_mgmt_packets_r & pkt_mgmt_pass;
		wake_now = pkt_done & (any_enabled | any_mgmt_flex) & ~mgmt_blocked;
	end

	// One pulse per waking packet; ce low holds it
	always @(posedge clk) begin
		if (srst) begin
			wake_event_r <= 1'b0;
		end else if (ce) begin
			wake_event_r <= wake_now;
		end
	end

	// ----------------------------------------
	// Event status
	// ----------------------------------------
	// Cleared by power-on reset only, so a host bus reset
	// does not lose the record of what woke the system
	reg  [31:0] status_nxt;
	reg  [31:0] status_set;
	wire [31:0] status_clr;

	assign status_clr = wr_sel[`WF_SEL_EVENT_STAT] ? reg_wdata : 32'h00000000;

	always @* begin
		status_set = 32'h00000000;
		if (wake_now) begin
			// Every criterion the packet met, not only the first
			status_set = crit;
		end
		// Set beats a clear landing in the same cycle
		status_nxt = ((wake_status_r & ~status_clr) | status_set) & `WF_MASK_EVENT_STAT;
	end

	// One flag per bit; reserved positions are masked out of
	// status_nxt and so never leave their reset value
	localparam [31:0] STATUS_RST = `WF_RST_EVENT_STAT;

	genvar b;
	generate
		for (b = 0; b < 32; b = b + 1) begin : g_status
			always @(posedge clk) begin
				if (por_rst) begin
					wake_status_r[b] <= STATUS_RST[b];
				end else if (ce) begin
					wake_status_r[b] <= status_nxt[b];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Management ports
	// ----------------------------------------
	// Host writes a pair, management bus writes one port;
	// on a clash the management bus wins that port
	genvar p;
	generate
		for (p = 0; p < 4; p = p + 1) begin : g_port
			wire              host_hit;
			wire              mgmt_hit;
			wire [PORT_W-1:0] host_val;

			assign host_hit = wr_sel[`WF_SEL_PORT_LOW + (p / 2)];
			assign mgmt_hit = mgmt_port_wr && ({30'h0, mgmt_port_idx} == p);
			// Even port low half, odd port high half
			assign host_val = reg_wdata[16*(p%2) +: PORT_W];

			always @(posedge clk) begin
				if (srst) begin
					mgmt_ports_r[PORT_W*p +: PORT_W] <= `WF_RST_PORT;
				end else if (ce) begin
					if (mgmt_hit) begin
						mgmt_ports_r[PORT_W*p +: PORT_W] <= mgmt_port_data;
					end else if (host_hit) begin
						mgmt_ports_r[PORT_W*p +: PORT_W] <= host_val;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Address valid flags
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			ipv4_valid_r <= {ENTRIES{1'b0}};
		end else if (ce) begin
			if (wr_sel[`WF_SEL_ADDR_VALID]) begin
				ipv4_valid_r <= reg_wdata[`WF_BIT_IPV4_VALID_LO +: ENTRIES];
			end else if (nvm_load) begin
				// Loader runs after reset release, so the strap is
				// caught by the clock, never by the reset itself
				ipv4_valid_r[0] <= nvm_ip_valid;
			end
		end
	end

	// Only the flag lives here, not the address it marks
	always @(posedge clk) begin
		if (srst) begin
			ipv6_entry_valid_r <= 1'b0;
		end else if (ce && wr_sel[`WF_SEL_ADDR_VALID]) begin
			ipv6_entry_valid_r <= reg_wdata[`WF_BIT_IPV6_VALID];
		end
	end

	// ----------------------------------------
	// IPv4 address table
	// ----------------------------------------
	// Contents are undefined to software after reset; they are
	// cleared anyway so simulation shows no unknowns
	genvar e;
	generate
		for (e = 0; e < ENTRIES; e = e + 1) begin : g_ipv4
			always @(posedge clk) begin
				if (srst) begin
					ipv4_table_r[32*e +: 32] <= `WF_RST_IPV4;
				end else if (ce && wr_sel[`WF_SEL_IPV4_0 + e]) begin
					ipv4_table_r[32*e +: 32] <= reg_wdata;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Destination compare
	// ----------------------------------------
	// Flags and table as they stand this cycle; hits show next cycle
	wire [ENTRIES-1:0] ip_hit;

	ipv4_match #(
		.ENTRIES    (ENTRIES)
	) u_match (
		.table_flat  (ipv4_table_r),
		.entry_valid (ipv4_valid_r),
		.pkt_ip      (pkt_dst_ip),
		.hit         (ip_hit)
	);

	always @(posedge clk) begin
		if (srst) begin
			ipv4_hit_r <= {ENTRIES{1'b0}};
		end else if (ce) begin
			ipv4_hit_r <= ip_hit;
		end
	end

	// Entry 0 doubles as the management routing address
	always @(posedge clk) begin
		if (srst) begin
			mgmt_ip_hit_r <= 1'b0;
		end else if (ce) begin
			mgmt_ip_hit_r <= ip_hit[0];
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	reg [31:0] rd_mux;
	integer    k;

	always @* begin
		rd_mux = 32'h00000000;
		if (rd_sel[`WF_SEL_FILTER_EN]) begin
			rd_mux = filter_enable_r;
		end
		if (rd_sel[`WF_SEL_EVENT_STAT]) begin
			rd_mux = wake_status_r;
		end
		if (rd_sel[`WF_SEL_PORT_LOW]) begin
			rd_mux = mgmt_ports_r[0 +: 32];
		end
		if (rd_sel[`WF_SEL_PORT_HIGH]) begin
			rd_mux = mgmt_ports_r[32 +: 32];
		end
		if (rd_sel[`WF_SEL_ADDR_VALID]) begin
			// Gap between the two flag groups stays zero
			rd_mux[`WF_BIT_IPV4_VALID_LO +: ENTRIES] = ipv4_valid_r;
			rd_mux[`WF_BIT_IPV6_VALID] = ipv6_entry_valid_r;
		end
		for (k = 0; k < ENTRIES; k = k + 1) begin
			if (rd_sel[`WF_SEL_IPV4_0 + k]) begin
				rd_mux = ipv4_table_r[32*k +: 32];
			end
		end
	end

	// Unmapped reads answer zero, one cycle later like any other
	always @(posedge clk) begin
		if (srst) begin
			reg_rdata_r  <= 32'h00000000;
			reg_rvalid_r <= 1'b0;
		end else if (ce) begin
			reg_rvalid_r <= reg_rd;
			if (reg_rd) begin
				reg_rdata_r <= rd_mux;
			end
		end
	end

endmodule

// *** verif/wake_filter_regs_sva.sv ***
`timescale 1ns/1ps
`include "wake_filter_defines.vh"
module wake_filter_regs_sva (
	// Block ports
	input wire        clk,
	input wire        srst,
	input wire        por_rst,
	input wire        ce,
	input wire [15:0] reg_addr,
	input wire        reg_wr,
	input wire [31:0] reg_wdata,
	input wire        reg_rd,
	input wire        reg_rvalid_r,
	input wire        mgmt_port_wr,
	input wire [1:0]  mgmt_port_idx,
	input wire [15:0] mgmt_port_data,
	input wire [63:0] mgmt_ports_r,
	input wire        pkt_done,
	input wire [31:0] pkt_match,
	input wire        pkt_mgmt_pass,
	input wire [1:0]  mgmt_flex_alloc,
	input wire [31:0] filter_enable_r,
	input wire        ignore_mgmt_packets_r,
	input wire        wake_event_r,
	input wire [31:0] wake_status_r
);
	wire en_wr = ce && reg_wr && reg_addr == `WF_OFF_FILTER_EN;
	wire st_wr = ce && reg_wr && reg_addr == `WF_OFF_EVENT_STAT;
	wire blk = pkt_mgmt_pass && ignore_mgmt_packets_r;
	default clocking @(posedge clk); endclocking
	default disable iff (srst || por_rst);
	a_read_answer: assert property (ce && reg_rd |=> reg_rvalid_r) else $error("no read answer");
	a_enable_store: assert property (en_wr |=> filter_enable_r == ($past(reg_wdata) & `WF_MASK_FILTER_EN))
		else $error("enable not stored");
	a_mgmt_no_wake: assert property (ce && pkt_done && blk |=> !wake_event_r) else $error("mgmt wake");
	a_wake_records: assert property (ce && pkt_done && !blk && |(pkt_match & filter_enable_r & `WF_MASK_WAKE_EN)
		|=> wake_event_r && &(wake_status_r | ~($past(pkt_match) & `WF_MASK_WAKE_EN))) else $error("wake lost");
	a_status_clear: assert property (st_wr && !pkt_done
		|=> wake_status_r == ($past(wake_status_r) & ~$past(reg_wdata))) else $error("clear wrong");
	a_status_kept: assert property (disable iff (por_rst) !por_rst && !(ce && (pkt_done || st_wr))
		|=> $stable(wake_status_r)) else $error("status moved");
	a_flex_unalloc: assert property (ce && pkt_done && !mgmt_flex_alloc[0] && !wake_status_r[9]
		|=> !wake_status_r[9]) else $error("unallocated flex set");
	a_reserved_zero: assert property ((wake_status_r & ~`WF_MASK_EVENT_STAT) == 32'h0) else $error("reserved set");
	a_mgmt_port3: assert property (ce && mgmt_port_wr && mgmt_port_idx == 2'h3
		|=> mgmt_ports_r[63:48] == $past(mgmt_port_data)) else $error("port write lost");
	c_wake: cover property (wake_event_r);
	c_blocked: cover property (ce && pkt_done && blk);
	c_clear: cover property (st_wr && |wake_status_r);
	c_port: cover property (mgmt_port_wr);
endmodule
bind wake_filter_regs wake_filter_regs_sva u_wake_filter_regs_sva (.clk, .srst, .por_rst, .ce, .reg_addr, .reg_wr,
	.reg_wdata, .reg_rd, .reg_rvalid_r, .mgmt_port_wr, .mgmt_port_idx, .mgmt_port_data, .mgmt_ports_r, .pkt_done,
	.pkt_match, .pkt_mgmt_pass, .mgmt_flex_alloc, .filter_enable_r, .ignore_mgmt_packets_r, .wake_event_r, .wake_status_r);

// *** verif/wake_filter_regs_tb_top.sv ***
`timescale 1ns/1ps
`include "wake_filter_defines.vh"
module wake_filter_regs_tb_top;
	logic         clk = 0, srst = 1, por_rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, mgmt_port_wr = 0;
	logic         nvm_load = 0, nvm_ip_valid = 0, pkt_done = 0, pkt_mgmt_pass = 0;
	logic [15:0]  reg_addr = 0, mgmt_port_data = 0;
	logic [31:0]  reg_wdata = 0, pkt_match = 0, pkt_dst_ip = 0, reg_rdata_r, filter_enable_r, wake_status_r;
	logic [1:0]   mgmt_port_idx = 0, mgmt_flex_alloc = 0;
	logic         reg_rvalid_r, ignore_mgmt_packets_r, ipv6_entry_valid_r, wake_event_r, mgmt_ip_hit_r;
	logic [63:0]  mgmt_ports_r;
	logic [3:0]   ipv4_valid_r, ipv4_hit_r;
	logic [127:0] ipv4_table_r;
	int           errors = 0, check_count = 0;
	always #2.5 clk = ~clk;
	wake_filter_regs u_wake_filter_regs (.clk, .srst, .por_rst, .ce, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata_r, .reg_rvalid_r, .mgmt_port_wr, .mgmt_port_idx, .mgmt_port_data, .nvm_load, .nvm_ip_valid,
		.pkt_done, .pkt_match, .pkt_mgmt_pass, .mgmt_flex_alloc, .pkt_dst_ip, .filter_enable_r,
		.ignore_mgmt_packets_r, .mgmt_ports_r, .ipv4_valid_r, .ipv6_entry_valid_r, .ipv4_table_r,
		.wake_event_r, .wake_status_r, .ipv4_hit_r, .mgmt_ip_hit_r);
	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
		@(posedge clk); reg_wr <= 0;
	endtask
	task rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge clk); reg_addr <= a; reg_rd <= 1;
		@(posedge clk); reg_rd <= 0;
		#1 chk("rdata", {32'h0, e}, {32'h0, reg_rdata_r});
		chk("rvalid", 64'h1, {63'h0, reg_rvalid_r});
	endtask
	task pkt(input logic [31:0] m, input logic mp, input logic w);
		@(posedge clk); pkt_match <= m; pkt_mgmt_pass <= mp; pkt_done <= 1;
		@(posedge clk); pkt_done <= 0;
		#1 chk("wake", {63'h0, w}, {63'h0, wake_event_r});
	endtask
	task pulse_rst(input logic p);
		@(posedge clk); srst <= !p; por_rst <= p;
		@(posedge clk); srst <= 0; por_rst <= 0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_enable;
		rd(16'h5800, 32'h0);
		wr(`WF_OFF_FILTER_EN, 32'hffffffff);
		rd(`WF_OFF_FILTER_EN, `WF_MASK_FILTER_EN);
		chk("ignore", 64'h1, {63'h0, ignore_mgmt_packets_r});
		chk("enable", {32'h0, `WF_MASK_FILTER_EN}, {32'h0, filter_enable_r});
		wr(`WF_OFF_FILTER_EN, 32'h00000010);
	endtask
	task t_wake;
		pkt(32'h14, 0, 1);
		pkt(32'h8, 0, 0);
		pkt(32'h10, 1, 1);
		rd(`WF_OFF_EVENT_STAT, 32'h14);
		chk("status", 64'h14, {32'h0, wake_status_r});
		wr(`WF_OFF_FILTER_EN, 32'h00008010);
		pkt(32'h10, 1, 0);
		pkt(32'h200, 0, 0);
		@(posedge clk); mgmt_flex_alloc <= 2'h1;
		pkt(32'h00090600, 0, 1);
		rd(`WF_OFF_EVENT_STAT, 32'h00090214);
	endtask
	task t_clear;
		wr(`WF_OFF_EVENT_STAT, 32'h00010004);
		rd(`WF_OFF_EVENT_STAT, 32'h00080210);
		pulse_rst(0);
		rd(`WF_OFF_EVENT_STAT, 32'h00080210);
		rd(`WF_OFF_FILTER_EN, 32'h0);
		pulse_rst(1);
		rd(`WF_OFF_EVENT_STAT, 32'h0);
	endtask
	task t_ports;
		wr(`WF_OFF_PORT_LOW, 32'h22221111);
		wr(`WF_OFF_PORT_HIGH, 32'h44443333);
		@(posedge clk); mgmt_port_idx <= 2'h3; mgmt_port_data <= 16'hbeef; mgmt_port_wr <= 1;
		@(posedge clk); mgmt_port_wr <= 0;
		rd(`WF_OFF_PORT_HIGH, 32'hbeef3333);
		chk("ports", 64'hbeef333322221111, mgmt_ports_r);
		@(posedge clk); reg_addr <= `WF_OFF_PORT_LOW; reg_wdata <= 32'h66665555; reg_wr <= 1;
		mgmt_port_idx <= 2'h0; mgmt_port_data <= 16'h7777; mgmt_port_wr <= 1;
		@(posedge clk); reg_wr <= 0; mgmt_port_wr <= 0;
		rd(`WF_OFF_PORT_LOW, 32'h66667777);
	endtask
	task t_freeze;
		@(posedge clk); ce <= 0;
		wr(`WF_OFF_PORT_LOW, 32'h12345678);
		@(posedge clk); ce <= 1;
		rd(`WF_OFF_PORT_LOW, 32'h66667777);
	endtask
	task t_ipv4;
		for (int i = 0; i < 4; i++) wr(`WF_OFF_IPV4_0 + 16'(8 * i), 32'h0201a8c0 + 32'(i << 24));
		for (int i = 0; i < 4; i++) rd(`WF_OFF_IPV4_0 + 16'(8 * i), 32'h0201a8c0 + 32'(i << 24));
		chk("table_hi", 64'h0501a8c00401a8c0, ipv4_table_r[127:64]);
		chk("table_lo", 64'h0301a8c00201a8c0, ipv4_table_r[63:0]);
		wr(`WF_OFF_ADDR_VALID, 32'hffffffff);
		rd(`WF_OFF_ADDR_VALID, `WF_MASK_ADDR_VALID);
		chk("v4_valid", 64'hf, {60'h0, ipv4_valid_r});
		chk("v6_valid", 64'h1, {63'h0, ipv6_entry_valid_r});
		@(posedge clk); nvm_ip_valid <= 0; nvm_load <= 1;
		@(posedge clk); nvm_load <= 0; pkt_dst_ip <= 32'h0301a8c0;
		rd(`WF_OFF_ADDR_VALID, 32'h0001000e);
		chk("hit", 64'h2, {60'h0, ipv4_hit_r});
		@(posedge clk); nvm_ip_valid <= 1; nvm_load <= 1; pkt_dst_ip <= 32'h0201a8c0;
		@(posedge clk); nvm_load <= 0;
		repeat (3) @(posedge clk);
		#1 chk("mgmt_hit", 64'h1, {63'h0, mgmt_ip_hit_r});
	endtask
	task final_report;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Run is about a hundred cycles; limit leaves wide margin
	initial begin
		#50000;
		errors++;
		final_report();
	end
	initial begin
		repeat (5) @(posedge clk);
		srst <= 0;
		por_rst <= 0;
		t_enable();
		t_wake();
		t_clear();
		t_ports();
		t_freeze();
		t_ipv4();
		final_report();
	end
endmodule
